// ### src/sopc_pkg.sv
// Purpose: constants and types for the system option / power control register bank
// Assumes: APB slave, 32-bit data, 8-bit registers in the low byte of each word
// Notes:   register offsets below are byte addresses on the APB
//
// Behaviour
// - clock select picks 1-kHz tick or bus clock
// - early reset-status write in window mode resets MCU
// - window mode only with bus clock selected
// - comparator output feeds first timer channel 0
// - two bits move second timer channel pins
// - two bits move first timer channel pins
// - write-once bits accept only first write
// - high id bit seven reads zero, unwritable
// - high id bits six to four reserved
// - id registers read-only, hard-coded part number
// - warning flag sets on low supply, also after reset
// - ack clears warning flag only without warning
// - warning interrupt requested while flag and enable
// - detect reset only with reset and detect enabled
// - stop-enable keeps detection alive in stop
// - detect enable gates detection, reset, stop bits
// - bandgap buffer enable drives buffer on
// - id registers readable at any time
// - write-once option bits readable, later writes ignored
package sopc_pkg;

    localparam int ADDR_W = 12;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_SYS_OPT_TWO = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_PART_ID_HI  = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PART_ID_LO  = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_PWR_CTRL_1  = 12'h00C;

    // system_options_two field positions
    localparam int SO_CLK_SEL  = 7;
    localparam int SO_WIN_MODE = 6;
    localparam int SO_CMP_CAP  = 4;
    localparam int SO_T2C1_PS  = 3;
    localparam int SO_T2C0_PS  = 2;
    localparam int SO_T1C1_PS  = 1;
    localparam int SO_T1C0_PS  = 0;
    localparam logic [7:0] SO_RESET   = 8'h00;
    localparam logic [7:0] SO_WO_MASK = 8'hC0; // write-once bits
    localparam logic [7:0] SO_RW_MASK = 8'h1F; // freely writable bits

    // power_mgmt_ctrl_one field positions
    localparam int PM_WARN_FLAG = 7;
    localparam int PM_WARN_CLR  = 6;
    localparam int PM_WARN_IE   = 5;
    localparam int PM_DROP_RE   = 4;
    localparam int PM_DROP_SE   = 3;
    localparam int PM_DROP_DE   = 2;
    localparam int PM_BG_BUF    = 0;
    localparam logic [7:0] PM_RESET   = 8'h1C;
    localparam logic [7:0] PM_WO_MASK = 8'h1C;
    localparam logic [7:0] PM_RW_MASK = 8'h21;

    // part id high layout
    localparam logic [3:0] ID_HI_TOP = 4'h0; // bit 7 tie-off and reserved 6:4

    // watchdog window: early portion is 3 of 4 quarters
    localparam int WIN_EARLY_NUM = 3;
    localparam int WIN_DEN       = 4;

    typedef struct packed {
        logic clk_sel;     // 1: bus clock, 0: 1-kHz tick
        logic window_mode; // effective window mode
    } sopc_wdog_cfg_t;

    typedef struct packed {
        logic timer2_ch1_pin_select;
        logic timer2_ch0_pin_select;
        logic timer1_ch1_pin_select;
        logic timer1_ch0_pin_select;
    } sopc_pin_sel_t;

endpackage

// ### src/sopc_regs.sv
// Purpose: system option and power-management control registers on APB
// Assumes: synchronous active-high reset is the MCU reset; inputs synchronous
// Notes:   zero-wait APB slave with registered read data; pslverr on unmapped address
`timescale 1ns/1ps
module sopc_regs
    import sopc_pkg::*;
#(
    parameter logic [11:0] PART_ID = 12'h0C3 // arbitrary value
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // watchdog side
    input  wire logic              lpo_tick_i,
    input  wire logic              srs_write_i,
    input  wire logic [15:0]       wdog_count_i,
    input  wire logic [15:0]       wdog_period_i,
    output sopc_wdog_cfg_t         wdog_cfg_o,
    output logic                   wdog_tick_o,
    output logic                   wdog_window_reset_o,
    // timer routing
    input  wire logic              cmp_out_i,
    input  wire logic              tmr1_ch0_pin_i,
    output logic                   tmr1_ch0_capture_o,
    output sopc_pin_sel_t          pin_sel_o,
    // power management
    input  wire logic              supply_warn_i,
    input  wire logic              supply_drop_i,
    input  wire logic              stop_mode_i,
    output logic                   warn_irq_o,
    output logic                   drop_detect_on_o,
    output logic                   drop_reset_o,
    output logic                   bandgap_buffer_enable_o
);

    // register state
    logic [7:0]  sys_opt_r;
    logic [7:0]  sys_opt_nxt;
    logic [7:0]  pwr_ctrl_r;
    logic [7:0]  pwr_ctrl_nxt;
    logic        so_lock_r;
    logic        pm_lock_r;
    logic        warn_flag_r;
    logic        warn_flag_nxt;
    logic [31:0] prdata_r;
    logic        win_reset_r;
    logic        drop_reset_r;

    // bus decode
    wire setup_w  = psel_i & ~penable_i;
    wire access_w = psel_i & penable_i;
    wire hit_so   = (paddr_i == OFS_SYS_OPT_TWO);
    wire hit_idh  = (paddr_i == OFS_PART_ID_HI);
    wire hit_idl  = (paddr_i == OFS_PART_ID_LO);
    wire hit_pm   = (paddr_i == OFS_PWR_CTRL_1);
    wire mapped   = hit_so | hit_idh | hit_idl | hit_pm;
    wire wr_lane0 = access_w & pwrite_i & pstrb_i[0];
    wire wr_so    = wr_lane0 & hit_so;
    wire wr_pm    = wr_lane0 & hit_pm;
    wire [7:0] wb = pwdata_i[7:0];

    // zero-wait answer; error only for an unmapped address
    assign pready_o  = access_w;
    assign pslverr_o = access_w & ~mapped;
    assign prdata_o  = prdata_r;

    // identification bytes: high byte top nibble fixed zero, id is hard wired
    wire [7:0] id_hi_w = {ID_HI_TOP, PART_ID[11:8]};
    wire [7:0] id_lo_w = PART_ID[7:0];

    // power control readback: clear bit always reads zero
    wire [7:0] pm_read_w = {warn_flag_r, 1'b0, pwr_ctrl_r[5:0]};

    // read mux, sampled in the setup cycle; id readable any time
    wire [7:0] rd_byte_w = hit_so  ? sys_opt_r :
                           hit_idh ? id_hi_w   :
                           hit_idl ? id_lo_w   :
                           hit_pm  ? pm_read_w : 8'h00;

    // system options next value: write-once bits only while unlocked
    assign sys_opt_nxt = wr_so ?
        ((sys_opt_r & ~SO_RW_MASK & ~(so_lock_r ? 8'h00 : SO_WO_MASK))
         | (wb & SO_RW_MASK)
         | (so_lock_r ? 8'h00 : (wb & SO_WO_MASK))) : sys_opt_r;

    // power control next value, same write-once treatment
    assign pwr_ctrl_nxt = wr_pm ?
        ((pwr_ctrl_r & ~PM_RW_MASK & ~(pm_lock_r ? 8'h00 : PM_WO_MASK))
         | (wb & PM_RW_MASK)
         | (pm_lock_r ? 8'h00 : (wb & PM_WO_MASK))) : pwr_ctrl_r;

    // warning flag: a present warning always wins over the clear
    wire warn_clr_w = wr_pm & wb[PM_WARN_CLR] & ~supply_warn_i;
    assign warn_flag_nxt = supply_warn_i | (warn_flag_r & ~warn_clr_w);

    // register block, all state back to defaults on reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sys_opt_r   <= SO_RESET;
            pwr_ctrl_r  <= PM_RESET;
            so_lock_r   <= 1'b0;
            pm_lock_r   <= 1'b0;
            warn_flag_r <= 1'b0;
            prdata_r    <= 32'h0000_0000;
        end else begin
            sys_opt_r   <= sys_opt_nxt;
            pwr_ctrl_r  <= pwr_ctrl_nxt;
            so_lock_r   <= so_lock_r | wr_so;
            pm_lock_r   <= pm_lock_r | wr_pm;
            warn_flag_r <= warn_flag_nxt;
            if (setup_w & ~pwrite_i) begin
                prdata_r <= {24'h00_0000, rd_byte_w};
            end
        end
    end

    // watchdog configuration decode
    wire clk_sel_w  = sys_opt_r[SO_CLK_SEL];
    wire win_eff_w  = sys_opt_r[SO_WIN_MODE] & clk_sel_w;
    assign wdog_cfg_o.clk_sel     = clk_sel_w;
    assign wdog_cfg_o.window_mode = win_eff_w;
    // counting tick: bus clock means every cycle, else the 1-kHz tick
    assign wdog_tick_o = clk_sel_w ? 1'b1 : lpo_tick_i;

    // early region: count below three quarters of the period
    wire [17:0] cnt_x4_w = {wdog_count_i, 2'b00};
    wire [17:0] per_x3_w = 18'({2'b00, wdog_period_i} * 18'(WIN_EARLY_NUM));
    wire        early_w  = cnt_x4_w < per_x3_w;
    wire        win_viol = win_eff_w & srs_write_i & early_w;

    // low-voltage detect qualification
    wire de_w = pwr_ctrl_r[PM_DROP_DE];
    wire detect_on_w = de_w & (~stop_mode_i | pwr_ctrl_r[PM_DROP_SE]);
    wire drop_rst_w  = detect_on_w & pwr_ctrl_r[PM_DROP_RE] & supply_drop_i;

    // reset requests leave from flip-flops
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            win_reset_r  <= 1'b0;
            drop_reset_r <= 1'b0;
        end else begin
            win_reset_r  <= win_viol;
            drop_reset_r <= drop_rst_w;
        end
    end
    assign wdog_window_reset_o = win_reset_r;
    assign drop_reset_o        = drop_reset_r;
    assign drop_detect_on_o    = detect_on_w;

    // interrupt level and bandgap buffer
    assign warn_irq_o = warn_flag_r & pwr_ctrl_r[PM_WARN_IE];
    assign bandgap_buffer_enable_o = pwr_ctrl_r[PM_BG_BUF];

    // timer routing and pin selects
    assign tmr1_ch0_capture_o = sys_opt_r[SO_CMP_CAP] ? cmp_out_i : tmr1_ch0_pin_i;
    assign pin_sel_o.timer2_ch1_pin_select = sys_opt_r[SO_T2C1_PS];
    assign pin_sel_o.timer2_ch0_pin_select = sys_opt_r[SO_T2C0_PS];
    assign pin_sel_o.timer1_ch1_pin_select = sys_opt_r[SO_T1C1_PS];
    assign pin_sel_o.timer1_ch0_pin_select = sys_opt_r[SO_T1C0_PS];

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_wo_bits_hold: assert property (
        so_lock_r & wr_so |=> sys_opt_r[7:6] == $past(sys_opt_r[7:6]))
        else $error("write-once option bits changed after lock");
    a_pm_wo_hold: assert property (
        pm_lock_r & wr_pm |=> pwr_ctrl_r[4:2] == $past(pwr_ctrl_r[4:2]))
        else $error("write-once power bits changed after lock");
    a_first_write_takes: assert property (
        ~so_lock_r & wr_so |=> sys_opt_r[7:6] == $past(wb[7:6]) && so_lock_r)
        else $error("first write to option register not accepted");
    a_window_reset: assert property (
        win_eff_w & srs_write_i & early_w |=> wdog_window_reset_o)
        else $error("early service write did not reset");
    a_window_needs_bus: assert property (
        ~clk_sel_w |-> ##1 ~wdog_window_reset_o)
        else $error("window reset without bus clock source");
    a_tick_source: assert property (
        clk_sel_w |-> wdog_tick_o)
        else $error("bus clock source not ticking every cycle");
    a_warn_sets: assert property (
        supply_warn_i |=> warn_flag_r)
        else $error("warning flag not set by low supply");
    a_warn_clear: assert property (
        warn_flag_r & wr_pm & wb[PM_WARN_CLR] & ~supply_warn_i |=> ~warn_flag_r)
        else $error("warning acknowledge did not clear flag");
    a_warn_irq: assert property (
        warn_irq_o |-> warn_flag_r && pwr_ctrl_r[PM_WARN_IE])
        else $error("warning interrupt without flag and enable");
    a_drop_reset: assert property (
        drop_reset_o |-> $past(supply_drop_i) && $past(pwr_ctrl_r[PM_DROP_DE]))
        else $error("detect reset without enabled detect event");
    a_id_constant: assert property (
        setup_w & ~pwrite_i & hit_idh |=> prdata_o[7:4] == 4'h0)
        else $error("high id top bits not zero");
    a_capture_route: assert property (
        sys_opt_r[SO_CMP_CAP] |-> tmr1_ch0_capture_o == cmp_out_i)
        else $error("comparator not routed to capture input");

    // further checks on routing, warning, detect and bus answer
    a_tick_slow: assert property (
        ~clk_sel_w |-> wdog_tick_o == lpo_tick_i)
        else $error("slow tick not passed to watchdog");
    a_window_src: assert property (
        wdog_window_reset_o |-> $past(clk_sel_w))
        else $error("window reset while slow clock selected");
    a_late_write_ok: assert property (
        srs_write_i & ~early_w |=> ~wdog_window_reset_o)
        else $error("late service write caused a reset");
    a_capture_pin: assert property (
        ~sys_opt_r[SO_CMP_CAP] |-> tmr1_ch0_capture_o == tmr1_ch0_pin_i)
        else $error("capture input not taken from pin");
    a_t2_pin_sel: assert property (
        wr_so |=> pin_sel_o.timer2_ch1_pin_select == $past(wb[SO_T2C1_PS])
              && pin_sel_o.timer2_ch0_pin_select == $past(wb[SO_T2C0_PS]))
        else $error("second timer pin select not written");
    a_t1_pin_sel: assert property (
        wr_so |=> pin_sel_o.timer1_ch1_pin_select == $past(wb[SO_T1C1_PS])
              && pin_sel_o.timer1_ch0_pin_select == $past(wb[SO_T1C0_PS]))
        else $error("first timer pin select not written");
    a_clear_refused: assert property (
        warn_flag_r & supply_warn_i |=> warn_flag_r)
        else $error("warning flag cleared while warning present");
    a_irq_on: assert property (
        warn_flag_r & pwr_ctrl_r[PM_WARN_IE] |-> warn_irq_o)
        else $error("warning interrupt missing");
    a_drop_fires: assert property (
        detect_on_w & pwr_ctrl_r[PM_DROP_RE] & supply_drop_i |=> drop_reset_o)
        else $error("enabled detect event did not reset");
    a_stop_gate: assert property (
        stop_mode_i & ~pwr_ctrl_r[PM_DROP_SE] |-> ~drop_detect_on_o)
        else $error("detection active in stop without stop enable");
    a_detect_off: assert property (
        ~pwr_ctrl_r[PM_DROP_DE] |=> ~drop_reset_o)
        else $error("detect reset with detect logic off");
    a_bandgap_wr: assert property (
        wr_pm |=> bandgap_buffer_enable_o == $past(wb[PM_BG_BUF]))
        else $error("bandgap buffer enable not written");
    a_id_low_read: assert property (
        setup_w & ~pwrite_i & hit_idl |=> prdata_o[7:0] == PART_ID[7:0])
        else $error("low id byte read wrong");

    c_window_violation: cover property (win_viol ##1 wdog_window_reset_o);
    c_locked_write:     cover property (wr_so ##[1:20] wr_so);
    c_warn_ack:         cover property (warn_flag_r ##1 warn_clr_w ##1 ~warn_flag_r);
    c_drop_reset:       cover property (drop_rst_w);

endmodule

// ### tb/sopc_regs_tb.sv
// Purpose: self-checking bench for the option and power control registers
// Assumes: zero-wait apb slave, one byte in the low lane of each word
// Notes:   scenarios re-arm the design through reset where locks matter
`timescale 1ns/1ps
module sopc_regs_tb;
    import sopc_pkg::*;
    localparam logic [11:0] ID = 12'h5A7; // arbitrary value
    logic              sys_clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata, q;
    logic              lpo = 1'b0, reset_status_reg = 1'b0, cmp = 1'b1, pin = 1'b0, cap;
    logic [15:0]       count = '0, period = 16'd100;
    sopc_wdog_cfg_t    wcfg;
    sopc_pin_sel_t     psl;
    logic              wtick, wrst, warn = 1'b0, drop = 1'b0, stop = 1'b0;
    logic              irq, don, drst, bg;
    int                miscompares = 0, compares = 0;

    sopc_regs #(.PART_ID(ID)) sopc_regs_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .lpo_tick_i(lpo), .srs_write_i(reset_status_reg), .wdog_count_i(count),
        .wdog_period_i(period), .wdog_cfg_o(wcfg), .wdog_tick_o(wtick),
        .wdog_window_reset_o(wrst), .cmp_out_i(cmp), .tmr1_ch0_pin_i(pin),
        .tmr1_ch0_capture_o(cap), .pin_sel_o(psl), .supply_warn_i(warn),
        .supply_drop_i(drop), .stop_mode_i(stop), .warn_irq_o(irq),
        .drop_detect_on_o(don), .drop_reset_o(drst), .bandgap_buffer_enable_o(bg));

    // free-running 100 MHz clock
    always #5 sys_clk_i = ~sys_clk_i;

    task automatic end_sim;
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk_i);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge sys_clk_i);
        pen <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk_i);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        {psel, pen} <= 2'b00;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, x});
    endtask

    task automatic rst(input int n);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        rst_i <= 1'b0;
    endtask

    // step one edge and let combinational outputs settle
    task automatic step;
        @(posedge sys_clk_i);
        #1;
    endtask

    // reset values, read-only id, unmapped address, slow tick routing
    task automatic t_reset;
        rdc(OFS_SYS_OPT_TWO, SO_RESET);
        rdc(OFS_PWR_CTRL_1, PM_RESET);
        wr(OFS_PART_ID_HI, 8'hFF);
        wr(OFS_PART_ID_LO, 8'h00);
        rdc(OFS_PART_ID_HI, {4'h0, ID[11:8]});
        rdc(OFS_PART_ID_LO, ID[7:0]);
        bus(1'b0, 12'h010, 8'h00);
        chk({q[31:1], e}, 32'h1);
        lpo <= 1'b1;
        step();
        chk({31'h0, wtick}, 32'h1);
        lpo <= 1'b0;
        step();
        chk({31'h0, wtick}, 32'h0);
    endtask

    // write-once lock, pin selects, comparator link, window boundary
    task automatic t_opts;
        wr(OFS_SYS_OPT_TWO, 8'hDF);
        rdc(OFS_SYS_OPT_TWO, 8'hDF);
        chk({30'h0, wcfg}, 32'h3);
        chk({31'h0, cap}, 32'h1);
        chk({28'h0, psl}, 32'hF);
        wr(OFS_SYS_OPT_TWO, 8'h05);
        rdc(OFS_SYS_OPT_TWO, 8'hC5);
        chk({28'h0, psl}, 32'h5);
        chk({31'h0, cap}, 32'h0);
        {count, reset_status_reg} <= {16'd74, 1'b1};
        step();
        chk({31'h0, wrst}, 32'h1);
        reset_status_reg <= 1'b0;
        step();
        {count, reset_status_reg} <= {16'd75, 1'b1};
        step();
        chk({31'h0, wrst}, 32'h0);
        reset_status_reg <= 1'b0;
        step();
    endtask

    // window bit without bus clock, lock re-armed by reset
    task automatic t_window_off;
        rst(2);
        wr(OFS_SYS_OPT_TWO, 8'h40);
        rdc(OFS_SYS_OPT_TWO, 8'h40);
        chk({30'h0, wcfg}, 32'h0);
        {count, reset_status_reg} <= {16'd0, 1'b1};
        step();
        reset_status_reg <= 1'b0;
        step();
        chk({31'h0, wrst}, 32'h0);
    endtask

    // warning flag across reset, refused and accepted clear, irq, bandgap
    task automatic t_power;
        warn <= 1'b1;
        rst(2);
        rdc(OFS_PWR_CTRL_1, 8'h9C);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_PWR_CTRL_1, 8'h61);
        rdc(OFS_PWR_CTRL_1, 8'hA1);
        chk({29'h0, irq, bg, don}, 32'h6);
        warn <= 1'b0;
        wr(OFS_PWR_CTRL_1, 8'h7D);
        rdc(OFS_PWR_CTRL_1, 8'h21);
        chk({31'h0, irq}, 32'h0);
        drop <= 1'b1;
        step();
        step();
        chk({31'h0, drst}, 32'h0);
        drop <= 1'b0;
    endtask

    // detect reset and stop-mode gating
    task automatic t_drop;
        rst(2);
        {drop, stop} <= 2'b11;
        step();
        chk({30'h0, don, drst}, 32'h3);
        wr(OFS_PWR_CTRL_1, 8'h14);
        step();
        chk({30'h0, don, drst}, 32'h0);
        stop <= 1'b0;
        step();
        chk({31'h0, don}, 32'h1);
        wr(OFS_PWR_CTRL_1, 8'h00);
        rdc(OFS_PWR_CTRL_1, 8'h14);
        drop <= 1'b0;
    endtask

    initial begin
        rst(20);
        t_reset();
        t_opts();
        t_window_off();
        t_power();
        t_drop();
        end_sim();
    end
endmodule
